// ===== design/serial_test_tx_regs.vh
/*
  Register map, field positions, reset values and frame timing of the
  serial test transmitter.
  Assumes it is included by bare name from the design file.
*/
`ifndef SERIAL_TEST_TX_REGS_VH
`define SERIAL_TEST_TX_REGS_VH

// ****************************************
// byte addresses on the register bus
// ****************************************
`define KEY_FIRST_ADDR 32'hffff0880
`define CONTROL_ADDR 32'hffff0884
`define KEY_SECOND_ADDR 32'hffff0888
`define BYTES_ONE_TWO_ADDR 32'hffff088c
`define BYTES_THREE_FOUR_ADDR 32'hffff0890
`define BYTES_FIVE_SIX_ADDR 32'hffff0894

// ****************************************
// unlock key values
// ****************************************
`define KEY_FIRST_VALUE 16'h0007
`define KEY_SECOND_VALUE 16'h00b9

// ****************************************
// control register fields
// ****************************************
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET_BIT 1
`define CTRL_COUNT_LSB 2
`define CTRL_COUNT_MSB 4
`define CTRL_STATE_LSB 5
`define CTRL_STATE_MSB 8
`define CTRL_RESET_VALUE 5'h00
`define DATA_RESET_VALUE 16'h0000

// ****************************************
// frame length in baud ticks, and most bytes per transfer
// ****************************************
`define FRAME_BITS 4'hc
`define MAX_BYTES 3'h6

`endif

// ===== design/serial_test_tx.v
/*
  Serial test transmitter: AHB-Lite register slave, key-protected control
  register, three data registers, a two-entry byte buffer and a 12-bit
  frame shifter driving one output pin.
  Assumes a single AHB-Lite master, hready tied back from hreadyout, and a
  one-cycle baud_tick pulse from an external timer at the bit rate.
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_test_tx_regs.vh"

// How it works
// - each byte framed as start, eight data, even parity, two stop bits
// - the pin moves on by one bit at each baud tick
// - one to six bytes go out back to back as separate frames
// - first key write of 0x0007 must directly precede a control write
// - second key write of 0x00b9 must directly follow to commit it
// - control write without a correct preceding first key is dropped
// - a pending control write without correct second key is cancelled
// - byte one from low half of first data register, byte two high half
// - bytes three to six from second and third registers, low half first
// - count field bits 4:2, 000 means one byte, up to 101 six bytes
// - read-only state bits 8:5 nonzero while sending, zero when idle
// - committed reset bit clears the interface, control reads all zeros
// - control bit 0 enables the port, zero turns it off
// - sending waits until every needed data register has been written
// - control reads differently while sending, original value when done
module serial_test_tx #(
  parameter BUF_WIDTH = 8,
  parameter BUF_DEPTH = 2,
  parameter BUF_PTR_W = 1
)(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire baud_tick,
  output reg test_pin
);

  // ****************************************
  // states
  // ****************************************
  localparam [2:0] K_IDLE = 3'b001;
  localparam [2:0] K_ARMED = 3'b010;
  localparam [2:0] K_PEND = 3'b100;

  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_WAIT = 4'b0010;
  localparam [3:0] S_SEND = 4'b0100;
  localparam [3:0] S_DRAIN = 4'b1000;

  // ****************************************
  // functions
  // ****************************************
  // count field to number of bytes, codes above five clamp to six
  function [2:0] byte_total;
    input [2:0] code;
    begin
      if (code > 3'h5)
        byte_total = `MAX_BYTES;
      else
        byte_total = code + 3'h1;
    end
  endfunction

  // data registers that must be written for a given count
  function [2:0] regs_needed;
    input [2:0] code;
    reg [2:0] n;
    begin
      n = byte_total(code);
      regs_needed = {n > 3'h4, n > 3'h2, 1'b1};
    end
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  reg dp_valid;
  reg dp_write;
  reg [31:0] dp_addr;
  reg rd_done;
  reg [2:0] key_state;
  reg [4:0] pend_ctrl;
  reg [4:0] ctrl;
  reg [15:0] data0;
  reg [15:0] data1;
  reg [15:0] data2;
  reg [2:0] written;
  reg [3:0] state;
  reg [2:0] tx_total;
  reg [2:0] tx_idx;
  reg [BUF_WIDTH-1:0] buf_mem [0:BUF_DEPTH-1];
  reg [BUF_PTR_W-1:0] buf_wr;
  reg [BUF_PTR_W-1:0] buf_rd;
  reg [BUF_PTR_W:0] buf_count;
  reg [11:0] frame_sr;
  reg [3:0] bits_left;
  reg [7:0] next_byte;
  reg [15:0] next_read;

  wire wr_go;
  wire rd_go;
  wire in_space;
  wire commit;
  wire soft_reset;
  wire abort;
  wire done;
  wire push_valid;
  wire push_ready;
  wire pop_valid;
  wire pop_ready;
  wire [3:0] state_field;
  wire [BUF_WIDTH-1:0] pop_byte;

  // ****************************************
  // bus slave
  // ****************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 32'h00000000;
    end
    else if (hready)
    begin
      dp_valid <= hsel & htrans[1];
      dp_write <= hwrite;
      dp_addr <= haddr;
    end
  end

  assign wr_go = dp_valid & dp_write;
  assign rd_go = dp_valid & ~dp_write & ~rd_done;
  // reads take one wait state so hrdata comes from a flip-flop
  assign hreadyout = ~rd_go;
  assign hresp = 1'b0;
  assign in_space = (dp_addr == `KEY_FIRST_ADDR) | (dp_addr == `CONTROL_ADDR)
    | (dp_addr == `KEY_SECOND_ADDR) | (dp_addr == `BYTES_ONE_TWO_ADDR)
    | (dp_addr == `BYTES_THREE_FOUR_ADDR) | (dp_addr == `BYTES_FIVE_SIX_ADDR);

  assign state_field = state & (S_SEND | S_DRAIN);

  always @*
  begin
    case (dp_addr)
      `CONTROL_ADDR: next_read = {7'h00, state_field, ctrl};
      `BYTES_ONE_TWO_ADDR: next_read = data0;
      `BYTES_THREE_FOUR_ADDR: next_read = data1;
      `BYTES_FIVE_SIX_ADDR: next_read = data2;
      default: next_read = 16'h0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_done <= 1'b0;
      hrdata <= 32'h00000000;
    end
    else
    begin
      rd_done <= rd_go;
      if (rd_go)
        hrdata <= {16'h0000, next_read};
    end
  end

  // ****************************************
  // key sequence and registers
  // ****************************************
  assign commit = wr_go && key_state == K_PEND && dp_addr == `KEY_SECOND_ADDR
    && hwdata[15:0] == `KEY_SECOND_VALUE;
  assign soft_reset = commit & pend_ctrl[`CTRL_RESET_BIT];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      key_state <= K_IDLE;
      pend_ctrl <= `CTRL_RESET_VALUE;
      ctrl <= `CTRL_RESET_VALUE;
      data0 <= `DATA_RESET_VALUE;
      data1 <= `DATA_RESET_VALUE;
      data2 <= `DATA_RESET_VALUE;
      written <= 3'h0;
    end
    else
    begin
      if (wr_go && in_space)
      begin
        // any port write not continuing the sequence restarts it
        if (key_state == K_ARMED && dp_addr == `CONTROL_ADDR)
        begin
          pend_ctrl <= hwdata[4:0];
          key_state <= K_PEND;
        end
        else if (dp_addr == `KEY_FIRST_ADDR && hwdata[15:0] == `KEY_FIRST_VALUE
          && key_state != K_PEND)
          key_state <= K_ARMED;
        else if (dp_addr == `KEY_FIRST_ADDR && hwdata[15:0] == `KEY_FIRST_VALUE)
          key_state <= K_ARMED;
        else
          key_state <= K_IDLE;
      end
      if (soft_reset)
      begin
        ctrl <= `CTRL_RESET_VALUE;
        data0 <= `DATA_RESET_VALUE;
        data1 <= `DATA_RESET_VALUE;
        data2 <= `DATA_RESET_VALUE;
        written <= 3'h0;
      end
      else if (commit)
      begin
        ctrl <= pend_ctrl;
        written <= 3'h0;
      end
      else if (wr_go)
      begin
        // set wins over the clear at the end of a transfer
        case (dp_addr)
          `BYTES_ONE_TWO_ADDR:
          begin
            data0 <= hwdata[15:0];
            written <= (done ? 3'h0 : written) | 3'h1;
          end
          `BYTES_THREE_FOUR_ADDR:
          begin
            data1 <= hwdata[15:0];
            written <= (done ? 3'h0 : written) | 3'h2;
          end
          `BYTES_FIVE_SIX_ADDR:
          begin
            data2 <= hwdata[15:0];
            written <= (done ? 3'h0 : written) | 3'h4;
          end
          default:
            if (done)
              written <= 3'h0;
        endcase
      end
      else if (done)
        written <= 3'h0;
    end
  end

  // ****************************************
  // transfer sequencer
  // ****************************************
  assign abort = soft_reset | ~ctrl[`CTRL_ENABLE_BIT];
  assign done = (state == S_DRAIN) && buf_count == 0 && bits_left == 4'h0
    && baud_tick;
  assign push_valid = (state == S_SEND);

  always @*
  begin
    case (tx_idx)
      3'h0: next_byte = data0[7:0];
      3'h1: next_byte = data0[15:8];
      3'h2: next_byte = data1[7:0];
      3'h3: next_byte = data1[15:8];
      3'h4: next_byte = data2[7:0];
      default: next_byte = data2[15:8];
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= S_IDLE;
      tx_total <= 3'h1;
      tx_idx <= 3'h0;
    end
    else if (abort)
    begin
      state <= S_IDLE;
      tx_idx <= 3'h0;
    end
    else
    begin
      case (state)
        S_IDLE:
          state <= S_WAIT;
        S_WAIT:
          if ((written & regs_needed(ctrl[4:2])) == regs_needed(ctrl[4:2]))
          begin
            tx_total <= byte_total(ctrl[4:2]);
            tx_idx <= 3'h0;
            state <= S_SEND;
          end
        S_SEND:
          if (push_ready)
          begin
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == tx_total - 3'h1)
              state <= S_DRAIN;
          end
        S_DRAIN:
          if (done)
            state <= S_IDLE;
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // two-entry byte buffer
  // ****************************************
  assign push_ready = (buf_count != BUF_DEPTH);
  assign pop_valid = (buf_count != 0);
  assign pop_byte = buf_mem[buf_rd];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      buf_wr <= {BUF_PTR_W{1'b0}};
      buf_rd <= {BUF_PTR_W{1'b0}};
      buf_count <= {(BUF_PTR_W+1){1'b0}};
    end
    else if (abort)
    begin
      buf_wr <= {BUF_PTR_W{1'b0}};
      buf_rd <= {BUF_PTR_W{1'b0}};
      buf_count <= {(BUF_PTR_W+1){1'b0}};
    end
    else
    begin
      if (push_valid && push_ready)
        buf_wr <= buf_wr + 1'b1;
      if (pop_valid && pop_ready)
        buf_rd <= buf_rd + 1'b1;
      if ((push_valid && push_ready) && !(pop_valid && pop_ready))
        buf_count <= buf_count + 1'b1;
      else if (!(push_valid && push_ready) && (pop_valid && pop_ready))
        buf_count <= buf_count - 1'b1;
    end
  end

  always @(posedge hclk)
  begin
    if (push_valid && push_ready)
      buf_mem[buf_wr] <= next_byte;
  end

  // ****************************************
  // frame shifter
  // ****************************************
  // a new frame is taken only when the previous stop bit has run a full tick
  assign pop_ready = baud_tick && bits_left == 4'h0;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      frame_sr <= 12'hfff;
      bits_left <= 4'h0;
      test_pin <= 1'b1;
    end
    else if (abort)
    begin
      frame_sr <= 12'hfff;
      bits_left <= 4'h0;
      test_pin <= 1'b1;
    end
    else if (baud_tick)
    begin
      if (bits_left != 4'h0)
      begin
        test_pin <= frame_sr[0];
        frame_sr <= {1'b1, frame_sr[11:1]};
        bits_left <= bits_left - 4'h1;
      end
      else if (pop_valid)
      begin
        // stop, stop, parity, data lsb first, start
        test_pin <= 1'b0;
        frame_sr <= {1'b1, 2'b11, ^pop_byte, pop_byte};
        bits_left <= `FRAME_BITS - 4'h1;
      end
      else
        test_pin <= 1'b1;
    end
  end

endmodule // serial_test_tx
`default_nettype wire

// ===== test/stx_assertions.sv
/*
  port checker of the serial test transmitter.
  assumes a bind from tb_top and the register header on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_test_tx_regs.vh"
module stx_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic baud_tick,
  input wire logic test_pin
);
  // ********
  // checks
  // ********
  logic [3:0] low_ticks;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_taken; hsel && hready && htrans[1] && !hwrite; endsequence
  sequence wr_taken; hsel && hready && htrans[1] && hwrite; endsequence
  sequence rd_answer; !hreadyout ##1 hreadyout; endsequence
  // ticks seen while the pin stays low
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      low_ticks <= 4'h0;
    else if (test_pin)
      low_ticks <= 4'h0;
    else if (baud_tick)
      low_ticks <= low_ticks + 4'h1;
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_read_wait: assert property (rd_taken |=> rd_answer)
    else $error("read answer timing wrong");
  a_write_nowait: assert property (wr_taken |=> hreadyout)
    else $error("write stalled");
  a_pin_on_tick: assert property (
    (!$past(baud_tick) && !$stable(test_pin)) |-> test_pin)
    else $error("pin moved without a tick");
  a_low_bound: assert property (low_ticks <= 4'ha)
    else $error("pin low longer than start data parity");
  a_key_zero: assert property (
    (rd_taken and haddr == `KEY_FIRST_ADDR) |=> ##1 hrdata == 32'h0)
    else $error("key register read not zero");
  a_ctrl_reserved: assert property (
    (rd_taken and haddr == `CONTROL_ADDR) |=> ##1 hrdata[31:9] == 23'h0)
    else $error("reserved control bits not zero");
  a_unmapped_zero: assert property (
    (rd_taken and haddr == 32'hffff0898) |=> ##1 hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // stx_assertions
`default_nettype wire

// ===== test/diag_receiver.sv
/*
  diagnostic receiver model with its baud timer.
  assumes the pin idles high and moves one cycle after each tick.
*/
`timescale 1ns/1ps
`default_nettype none
module diag_receiver #(parameter int TICK = 8) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic test_pin,
  output logic baud_tick,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rx_err
);
  // ********
  // timer and frame capture
  // ********
  int cnt;
  logic [3:0] n;
  logic [10:0] sh;
  logic [10:0] full;
  assign full = {test_pin, sh[10:1]};
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cnt <= 0;
      baud_tick <= 1'b0;
      n <= 4'h0;
      sh <= 11'h0;
      rx_valid <= 1'b0;
      rx_byte <= 8'h0;
      rx_err <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
      baud_tick <= (cnt == TICK - 1);
      rx_valid <= 1'b0;
      if (baud_tick && n == 4'h0 && !test_pin)
        n <= 4'h1;
      else if (baud_tick && n != 4'h0)
      begin
        sh <= full;
        n <= (n == 4'hb) ? 4'h0 : n + 4'h1;
        if (n == 4'hb)
        begin
          rx_valid <= 1'b1;
          rx_byte <= full[7:0];
          rx_err <= (^full[8:0]) | ~full[9] | ~full[10];
        end
      end
    end
endmodule // diag_receiver
`default_nettype wire

// ===== test/tb_top.sv
/*
  self-checking bench of the serial test transmitter.
  assumes the design, the receiver model and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_test_tx_regs.vh"
module tb_top;
  // ********
  // bench
  // ********
  logic hclk, hresetn, hsel, hwrite, hready, baud_tick, test_pin;
  logic hreadyout, hresp, rx_valid, rx_err, mute;
  logic [31:0] haddr, hwdata, hrdata, rd, seed, wv;
  logic [1:0] htrans;
  logic [2:0] hsize, code;
  logic [7:0] rx_byte;
  logic [15:0] dat [3];
  logic [7:0] q [$];
  int n_errors, checks, k;
  assign hready = hreadyout;
  serial_test_tx uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .baud_tick(baud_tick),
    .test_pin(test_pin));
  diag_receiver #(.TICK(8)) peer (.hclk(hclk), .hresetn(hresetn), .test_pin(test_pin),
    .baud_tick(baud_tick), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_err(rx_err));
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic ctrl(input logic [31:0] v, input logic [31:0] k1);
    bus(1'b1, `KEY_FIRST_ADDR, 32'h7);
    bus(1'b1, `CONTROL_ADDR, v);
    bus(1'b1, `KEY_SECOND_ADDR, k1);
  endtask
  task automatic close_out;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // each received byte against the oldest note
  always @(posedge hclk)
    if (rx_valid && !mute)
    begin
      if (q.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk({24'h0, rx_byte}, {24'h0, q.pop_front()});
      chk(rx_err, 1'b0);
    end
  initial
  begin
    repeat (60000) @(posedge hclk);
    n_errors++;
    $display("unexpected at %0t: watchdog", $time);
    close_out;
  end
  initial
  begin
    {hresetn, hsel, hwrite, mute} = 4'h0;
    {haddr, hwdata, htrans} = 66'h0;
    hsize = 3'h2;
    seed = 32'he81a;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (k = 0; k < 4; k++)
    begin
      bus(1'b0, `CONTROL_ADDR + 4 * (k > 0 ? k + 1 : 0), 32'h0);
      chk(rd, 32'h0);
    end
    bus(1'b0, `KEY_FIRST_ADDR, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 32'hffff0898, 32'h0);
    chk(rd, 32'h0);
    $display("test reset values done");
    bus(1'b1, `CONTROL_ADDR, 32'h5);
    bus(1'b1, `KEY_SECOND_ADDR, 32'hb9);
    bus(1'b0, `CONTROL_ADDR, 32'h0);
    chk(rd, 32'h0);
    ctrl(32'h5, 32'h9);
    bus(1'b0, `CONTROL_ADDR, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `KEY_FIRST_ADDR, 32'h7);
    bus(1'b1, `BYTES_THREE_FOUR_ADDR, 32'h1234);
    bus(1'b1, `CONTROL_ADDR, 32'h5);
    bus(1'b1, `KEY_SECOND_ADDR, 32'hb9);
    bus(1'b0, `CONTROL_ADDR, 32'h0);
    chk(rd, 32'h0);
    $display("test key sequence done");
    // timer already running, then control, then data
    for (code = 3'h0; code < 3'h6; code++)
    begin
      wv = {27'h0, code, 2'b01};
      ctrl(wv, 32'hb9);
      for (k = 0; k < 3; k++)
      begin
        seed = lfsr(seed);
        dat[k] = seed[15:0];
      end
      for (k = 0; k <= code; k++)
        q.push_back(k[0] ? dat[k / 2][15:8] : dat[k / 2][7:0]);
      for (k = 0; k <= code / 2; k++)
      begin
        if (k == code / 2)
        begin
          repeat (40) @(posedge hclk);
          chk(test_pin, 1'b1);
        end
        bus(1'b1, `BYTES_ONE_TWO_ADDR + 4 * k, {16'h0, dat[k]});
      end
      for (k = 0; k < 400 && test_pin === 1'b1; k++) @(posedge hclk);
      bus(1'b0, `CONTROL_ADDR, 32'h0);
      chk(rd[8:5] != 4'h0, 1'b1);
      chk(rd == wv, 1'b0);
      for (k = 0; k < 2000 && rd !== wv; k++) bus(1'b0, `CONTROL_ADDR, 32'h0);
      chk(rd, wv);
      repeat (4) @(posedge hclk);
      chk(q.size(), 32'h0);
    end
    $display("test transfers done");
    ctrl(32'h1, 32'hb9);
    bus(1'b1, `BYTES_ONE_TWO_ADDR, 32'h00a5);
    for (k = 0; k < 400 && test_pin === 1'b1; k++) @(posedge hclk);
    mute <= 1'b1;
    ctrl(32'h0, 32'hb9);
    repeat (2) @(posedge hclk);
    chk(test_pin, 1'b1);
    ctrl(32'h2, 32'hb9);
    bus(1'b0, `CONTROL_ADDR, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, `BYTES_ONE_TWO_ADDR, 32'h0);
    chk(rd, 32'h0);
    $display("test disable and reset done");
    close_out;
  end
endmodule // tb_top
bind serial_test_tx stx_assertions chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .baud_tick(baud_tick), .test_pin(test_pin));
`default_nettype wire
